// [rtl/dbc_pkg.sv]
// constants for the channel ten to fifteen buffer code register slice
package dbc_pkg;
  localparam int unsigned DBC_ADDR_W   = 12;
  localparam int unsigned DBC_DATA_W   = 32;
  localparam int unsigned DBC_CODE_W   = 12;
  localparam int unsigned DBC_CODE_LSB = 4;
  localparam int unsigned DBC_NUM_CH   = 6;
  localparam int unsigned DBC_CH_IDX_W = 3;
  localparam int unsigned DBC_IDX_W    = 10;

  // register indices; the byte address of each is four times its index
  localparam logic [9:0] DBC_IDX_CHAN10 = 10'h01A;
  localparam logic [9:0] DBC_IDX_CHAN11 = 10'h01B;
  localparam logic [9:0] DBC_IDX_CHAN12 = 10'h01C;
  localparam logic [9:0] DBC_IDX_CHAN13 = 10'h01D;
  localparam logic [9:0] DBC_IDX_CHAN14 = 10'h01E;
  localparam logic [9:0] DBC_IDX_CHAN15 = 10'h01F;
  localparam logic [9:0] DBC_IDX_FIRST  = DBC_IDX_CHAN10;
  localparam logic [9:0] DBC_IDX_LAST   = DBC_IDX_CHAN15;

  localparam logic [11:0] DBC_CODE_RST = 12'h000;
  localparam logic [15:0] DBC_REG_RST  = 16'h0000;
  localparam logic [31:0] DBC_RDATA_Z  = 32'h0000_0000;
  localparam logic [3:0]  DBC_RSVD_VAL = 4'h0;
  localparam logic [15:0] DBC_UPPER_Z  = 16'h0000;
endpackage

// [rtl/dbc_code_mem.sv]
// six-entry store of twelve-bit buffer codes with a registered read port
`timescale 1ns/1ps
`default_nettype none
module dbc_code_mem
  import dbc_pkg::*;
(
  input  wire logic                           i_core_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_wr_en,
  input  wire logic [DBC_CH_IDX_W-1:0]        i_wr_idx,
  input  wire logic [1:0]                     i_wr_be,
  input  wire logic [DBC_CODE_W-1:0]          i_wr_code,
  input  wire logic [DBC_CH_IDX_W-1:0]        i_rd_idx,
  output logic      [DBC_CODE_W-1:0]          o_rd_code,
  output logic      [DBC_NUM_CH*DBC_CODE_W-1:0] o_codes
);
  logic [DBC_CODE_W-1:0] code_r   [DBC_NUM_CH];
  logic [DBC_CODE_W-1:0] code_nxt [DBC_NUM_CH];
  logic [DBC_CODE_W-1:0] rd_r;
  logic [DBC_CODE_W-1:0] rd_nxt;

  genvar g;
  generate
    for (g = 0; g < DBC_NUM_CH; g++) begin : g_entry
      always_comb begin
        code_nxt[g] = code_r[g];
        if (i_wr_en && (i_wr_idx == DBC_CH_IDX_W'(g))) begin
          // lane one carries code bits 11:4, lane zero code bits 3:0
          if (i_wr_be[1]) begin
            code_nxt[g][11:4] = i_wr_code[11:4];
          end
          if (i_wr_be[0]) begin
            code_nxt[g][3:0] = i_wr_code[3:0];
          end
        end
      end
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          code_r[g] <= DBC_CODE_RST;
        end else begin
          code_r[g] <= code_nxt[g];
        end
      end
      assign o_codes[g*DBC_CODE_W +: DBC_CODE_W] = code_r[g];
    end
  endgenerate

  always_comb begin
    rd_nxt = DBC_CODE_RST;
    if (i_rd_idx < DBC_CH_IDX_W'(DBC_NUM_CH)) begin
      rd_nxt = code_r[i_rd_idx];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_r <= DBC_CODE_RST;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign o_rd_code = rd_r;
endmodule
`default_nettype wire

// [rtl/dbc_regs.sv]
// apb slave holding the buffer codes of analog channels ten to fifteen
//
// Overview of operation
// - channels ten to fifteen sit at consecutive indices 0x1a through 0x1f.
// - all six sixteen-bit registers read zero after reset.
// - bits 15:4 hold a twelve-bit code; reads return the last write.
// - code is unsigned straight binary: zero lowest, all ones highest.
`timescale 1ns/1ps
`default_nettype none
module dbc_regs
  import dbc_pkg::*;
(
  input  wire logic                             i_core_clk,
  input  wire logic                             i_rst_n,
  input  wire logic [DBC_ADDR_W-1:0]            i_paddr,
  input  wire logic                             i_psel,
  input  wire logic                             i_penable,
  input  wire logic                             i_pwrite,
  input  wire logic [DBC_DATA_W-1:0]            i_pwdata,
  input  wire logic [3:0]                       i_pstrb,
  output logic      [DBC_DATA_W-1:0]            o_prdata,
  output logic                                  o_pready,
  output logic                                  o_pslverr,
  // channel ten in bits 11:0 up to channel fifteen in bits 71:60
  output logic      [DBC_NUM_CH*DBC_CODE_W-1:0] o_chan_code
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RESP = 2'b10
  } dbc_state_e;

  dbc_state_e                 state_r;
  dbc_state_e                 state_nxt;
  logic [DBC_DATA_W-1:0]      prdata_r;
  logic [DBC_DATA_W-1:0]      prdata_nxt;
  logic                       pready_r;
  logic                       pready_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic [DBC_CH_IDX_W-1:0]    idx_r;
  logic [DBC_CH_IDX_W-1:0]    idx_nxt;
  logic                       hit_r;
  logic                       hit_nxt;
  logic [DBC_IDX_W-1:0]       word_idx;
  logic                       addr_ok;
  logic                       setup;
  logic                       access;
  logic                       wr_en;
  logic [DBC_CODE_W-1:0]      rd_code;
  logic [DBC_NUM_CH*DBC_CODE_W-1:0] codes;

  assign word_idx = i_paddr[DBC_ADDR_W-1:2];
  assign addr_ok  = (i_paddr[1:0] == 2'b00)
                 && (word_idx >= DBC_IDX_FIRST)
                 && (word_idx <= DBC_IDX_LAST);
  assign setup    = i_psel && !i_penable;
  assign access   = i_psel && i_penable;
  // writes land on the edge at which the master sees pready high
  assign wr_en    = (state_r == ST_RESP) && access && i_pwrite && hit_r;

  always_comb begin
    state_nxt   = state_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    idx_nxt     = idx_r;
    hit_nxt     = hit_r;
    case (state_r)
      ST_IDLE: begin
        if (setup) begin
          idx_nxt   = DBC_CH_IDX_W'(word_idx - DBC_IDX_FIRST);
          hit_nxt   = addr_ok;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (access) begin
          pready_nxt  = 1'b1;
          pslverr_nxt = !hit_r;
          prdata_nxt  = DBC_RDATA_Z;
          if (hit_r && !i_pwrite) begin
            // code goes out unaltered in straight binary, low nibble zero
            prdata_nxt = {DBC_UPPER_Z, rd_code, DBC_RSVD_VAL};
          end
          state_nxt = ST_RESP;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= ST_IDLE;
      prdata_r  <= DBC_RDATA_Z;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      idx_r     <= '0;
      hit_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      idx_r     <= idx_nxt;
      hit_r     <= hit_nxt;
    end
  end

  // only pwdata bits 15:4 reach the store, so reserved bits never change
  dbc_code_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_en    (wr_en),
    .i_wr_idx   (idx_r),
    .i_wr_be    (i_pstrb[1:0]),
    .i_wr_code  (i_pwdata[15:DBC_CODE_LSB]),
    .i_rd_idx   (idx_nxt),
    .o_rd_code  (rd_code),
    .o_codes    (codes)
  );

  assign o_prdata    = prdata_r;
  assign o_pready    = pready_r;
  assign o_pslverr   = pslverr_r;
  assign o_chan_code = codes;

  // helper state for the checks below
  logic                    seen_r;
  logic [DBC_CODE_W-1:0]   stored_code;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  assign stored_code = codes[idx_r*DBC_CODE_W +: DBC_CODE_W];

  sequence s_setup;
    i_psel && !i_penable && (state_r == ST_IDLE);
  endsequence

  sequence s_wait_access;
    i_psel && i_penable && !o_pready;
  endsequence

  sequence s_answer;
    o_pready;
  endsequence

  chk_ready_timing: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_setup ##1 s_wait_access |=> s_answer ##1 !o_pready
  ) else $error("pready not raised two cycles after setup");

  chk_map_window: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_setup |=> (i_penable [*1]) ##1 (o_pslverr == !$past(addr_ok, 2))
  ) else $error("slave error does not match the mapped window");

  chk_reset_zero: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !seen_r |-> (o_chan_code == '0) && (o_prdata == DBC_RDATA_Z)
  ) else $error("registers not zero right after reset");

  chk_code_readback: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_en && (i_pstrb[1:0] == 2'b11)) |=> (stored_code == $past(i_pwdata[15:4]))
  ) else $error("stored code differs from the written value");

  chk_straight_binary: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (o_pready && !i_pwrite && !o_pslverr) |-> (o_prdata[15:4] == stored_code)
  ) else $error("read code is not the stored binary code");

  chk_reserved_zero: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_pready |-> (o_prdata[3:0] == DBC_RSVD_VAL) && (o_prdata[31:16] == DBC_UPPER_Z)
  ) else $error("reserved or upper read bits not zero");

  chk_err_no_write: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (o_pready && o_pslverr) |=> $stable(o_chan_code)
  ) else $error("unmapped access changed a code");
endmodule
`default_nettype wire

// [rtl/dbc_regs_unused_placeholder_removed.sv]
// no content; intentionally empty design-free file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verif/dbc_regs_test.sv]
// self-checking bench for the channel ten to fifteen buffer code registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module dbc_regs_test
  import dbc_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [31:0] r;
  logic [3:0]  pstrb;
  logic [71:0] chan_code;
  logic [11:0] exp_code [6];
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  dbc_regs i_dbc_regs (
    .i_core_clk  (clk),
    .i_rst_n     (rst_n),
    .i_paddr     (paddr),
    .i_psel      (psel),
    .i_penable   (penable),
    .i_pwrite    (pwrite),
    .i_pwdata    (pwdata),
    .i_pstrb     (pstrb),
    .o_prdata    (prdata),
    .o_pready    (pready),
    .o_pslverr   (pslverr),
    .o_chan_code (chan_code)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] addr_of(int ch);
    return 12'(4 * (8'h1A + ch));
  endfunction

  // one apb transfer; penable drops after pready, psel stays for a back-to-back setup
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    penable <= 1'b0;
  endtask

  task automatic idle();
    psel <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(int ch, logic [31:0] d, logic [3:0] s);
    apb(addr_of(ch), 1'b1, d, s);
    if (s[1]) exp_code[ch][11:4] = d[15:8];
    if (s[0]) exp_code[ch][3:0] = d[7:4];
    `CHK("wr_err", 1'b0, err)
  endtask

  task automatic rdchk(int ch);
    apb(addr_of(ch), 1'b0, xs(), 4'h0);
    `CHK("rd_data", {16'h0000, exp_code[ch], 4'h0}, rd)
    `CHK("rd_err", 1'b0, err)
  endtask

  task automatic check_all();
    idle();
    @(negedge clk);
    for (int ch = 0; ch < 6; ch++) begin
      `CHK("chan_code", exp_code[ch], chan_code[ch*12 +: 12])
    end
    @(posedge clk);
    for (int ch = 0; ch < 6; ch++) rdchk(ch);
    idle();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int ch = 0; ch < 6; ch++) exp_code[ch] = 12'h000;
    @(posedge clk);
    check_all();
  endtask

  initial begin
    logic [11:0] bad [4] = '{12'h064, 12'h080, 12'h06A, 12'h000};
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    seed = 32'd18416;
    do_reset();
    for (int ch = 0; ch < 6; ch++) wr(ch, 32'hFFFF_FFFF, 4'hF);
    check_all();
    for (int ch = 0; ch < 6; ch++) wr(ch, 32'h0000_0000, 4'h1);
    check_all();
    for (int i = 0; i < 4; i++) begin
      apb(bad[i], 1'b1, 32'hFFFF_FFFF, 4'hF);
      `CHK("err_flag", 1'b1, err)
      `CHK("err_data", 32'h0000_0000, rd)
    end
    check_all();
    for (int i = 0; i < 60; i++) begin
      r = xs();
      wr(r[2:0] % 6, xs(), r[7:4]);
      if (r[8]) rdchk(r[2:0] % 6);
      if (r[9]) check_all();
    end
    check_all();
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
